// [fast_pulse_counter_pkg.sv]
package fast_pulse_counter_pkg;

	// Clock and derived timing references
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_US = 1;
	localparam int US_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	localparam int REF_FAST_HZ = 10_000_000;
	localparam int REF_SLOW_HZ = 1_000_000;
	localparam int REF_FAST_CYCLES = CLK_HZ / REF_FAST_HZ;
	localparam int REF_SLOW_CYCLES = CLK_HZ / REF_SLOW_HZ;
	localparam int US_PER_SEC = 1_000_000;

	// Register map, byte offsets within one counter, and counter stride
	localparam logic [7:0] OFF_CFG = 8'h00;
	localparam logic [7:0] OFF_FN = 8'h04;
	localparam logic [7:0] OFF_PRE = 8'h08;
	localparam logic [7:0] OFF_SW = 8'h0C;
	localparam logic [7:0] OFF_ACC = 8'h10;
	localparam logic [7:0] OFF_LAT = 8'h14;
	localparam logic [7:0] CNT_STRIDE = 8'h20;
	localparam int NUM_CNT = 2;
	localparam int NUM_PIN = 4;
	localparam int NUM_FN = 5;

	// Reset values
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	localparam logic [31:0] FN_RST = 32'h071C_71C7;
	localparam logic [31:0] PRE_RST = 32'h0000_0000;
	localparam logic [31:0] SW_RST = 32'h0000_0000;

	// Configuration word fields
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_SUB_LSB = 4;
	localparam int CFG_IN1_LSB = 8;
	localparam int CFG_IN2_LSB = 10;
	localparam int CFG_IN2_EN = 12;
	localparam int CFG_REF_SEL = 13;

	// Special function word: per function a source and a polarity
	localparam int FN_STRIDE = 6;
	localparam int FN_POL_LSB = 3;
	localparam int FN_DIS = 0;
	localparam int FN_LAT = 1;
	localparam int FN_PRE = 2;
	localparam int FN_CLR = 3;
	localparam int FN_MRK = 4;
	localparam logic [2:0] SRC_SW = 3'h4;

	// Trigger polarities
	localparam logic [1:0] POL_HIGH = 2'h0;
	localparam logic [1:0] POL_LOW = 2'h1;
	localparam logic [1:0] POL_FALL = 2'h2;
	localparam logic [1:0] POL_RISE = 2'h3;

	// Counter modes
	localparam logic [2:0] MODE_TOT = 3'h0;
	localparam logic [2:0] MODE_FREQ = 3'h1;
	localparam logic [2:0] MODE_PW = 3'h2;
	localparam logic [2:0] MODE_PER = 3'h3;
	localparam logic [2:0] MODE_QUAD = 3'h4;

	// Totalizer sub-modes
	localparam logic [2:0] TOT_INT = 3'h0;
	localparam logic [2:0] TOT_UP = 3'h1;
	localparam logic [2:0] TOT_DOWN = 3'h2;
	localparam logic [2:0] TOT_UPDN = 3'h3;
	localparam logic [2:0] TOT_CLKDIR = 3'h4;

	// Events seen on one filtered input
	typedef struct packed {
		logic lvl;
		logic rise;
		logic fall;
	} sig_t;

endpackage

// [fast_pulse_counter.sv]
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module fast_pulse_counter #(
	parameter int WIN0_US = 1000,
	parameter int WIN1_US = 10000,
	parameter int WIN2_US = 100000,
	parameter int WIN3_US = 1000000
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] pin_in
);

	localparam int NC = fast_pulse_counter_pkg::NUM_CNT;
	localparam int NF = fast_pulse_counter_pkg::NUM_FN;

	// Trigger test for one special function source
	function automatic logic fire(input logic lvl, input logic prv,
		input logic [1:0] pol);
		logic r;
		r = 1'b0;
		unique case (pol)
			fast_pulse_counter_pkg::POL_HIGH: r = lvl;
			fast_pulse_counter_pkg::POL_LOW: r = ~lvl;
			fast_pulse_counter_pkg::POL_FALL: r = prv & ~lvl;
			fast_pulse_counter_pkg::POL_RISE: r = ~prv & lvl;
		endcase
		return r;
	endfunction

	// Which special functions a mode lets through
	function automatic logic allowed(input logic [2:0] mode, input int f);
		logic r;
		r = 1'b0;
		if (f == fast_pulse_counter_pkg::FN_DIS
			|| f == fast_pulse_counter_pkg::FN_LAT)
		begin
			r = 1'b1;
		end
		else if (f == fast_pulse_counter_pkg::FN_MRK)
		begin
			r = (mode == fast_pulse_counter_pkg::MODE_QUAD);
		end
		else
		begin
			// Preload and clear only count-type modes
			r = (mode == fast_pulse_counter_pkg::MODE_TOT)
				|| (mode == fast_pulse_counter_pkg::MODE_QUAD);
		end
		return r;
	endfunction

	// Address decode: {valid, counter, register index}
	function automatic logic [4:0] decode(input logic [7:0] a);
		logic [7:0] off;
		logic [4:0] r;
		off = a % fast_pulse_counter_pkg::CNT_STRIDE;
		r = {1'b1, (a >= fast_pulse_counter_pkg::CNT_STRIDE), 3'h0};
		unique case (off)
			fast_pulse_counter_pkg::OFF_CFG: r[2:0] = 3'h0;
			fast_pulse_counter_pkg::OFF_FN: r[2:0] = 3'h1;
			fast_pulse_counter_pkg::OFF_PRE: r[2:0] = 3'h2;
			fast_pulse_counter_pkg::OFF_SW: r[2:0] = 3'h3;
			fast_pulse_counter_pkg::OFF_ACC: r[2:0] = 3'h4;
			fast_pulse_counter_pkg::OFF_LAT: r[2:0] = 3'h5;
			default: r[4] = 1'b0;
		endcase
		if (a >= 8'(2 * fast_pulse_counter_pkg::CNT_STRIDE))
		begin
			r[4] = 1'b0;
		end
		return r;
	endfunction

	// Input synchroniser and glitch filter state
	logic [3:0] s1_q, s2_q, s3_q, flt_q, fprev_q;
	logic [3:0] flt_d;
	fast_pulse_counter_pkg::sig_t pin_ev [4];

	// A pin change counts only once stages two and three agree
	always_comb
	begin
		flt_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & flt_q);
		for (int i = 0; i < 4; i++)
		begin
			pin_ev[i].lvl = flt_q[i];
			pin_ev[i].rise = flt_q[i] & ~fprev_q[i];
			pin_ev[i].fall = ~flt_q[i] & fprev_q[i];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_q <= 4'h0;
			s2_q <= 4'h0;
			s3_q <= 4'h0;
			flt_q <= 4'h0;
			fprev_q <= 4'h0;
		end
		else
		begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			flt_q <= flt_d;
			fprev_q <= flt_q;
		end
	end

	// Time bases: 1 us tick and the two internal reference rates
	logic [6:0] us_cnt_q, us_cnt_d;
	logic [6:0] ref_cnt_q, ref_cnt_d;
	logic [3:0] fast_cnt_q, fast_cnt_d;
	logic us_tick, fast_tick, slow_tick;

	always_comb
	begin
		us_tick = (us_cnt_q == 7'(fast_pulse_counter_pkg::US_CYCLES - 1));
		fast_tick = (fast_cnt_q
			== 4'(fast_pulse_counter_pkg::REF_FAST_CYCLES - 1));
		// Own divider for the slow reference, so its rate stays put
		// even if the microsecond tick is ever retimed
		slow_tick = (ref_cnt_q
			== 7'(fast_pulse_counter_pkg::REF_SLOW_CYCLES - 1));
		us_cnt_d = us_tick ? 7'h00 : us_cnt_q + 7'h01;
		fast_cnt_d = fast_tick ? 4'h0 : fast_cnt_q + 4'h1;
		ref_cnt_d = slow_tick ? 7'h00 : ref_cnt_q + 7'h01;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			us_cnt_q <= 7'h00;
			ref_cnt_q <= 7'h00;
			fast_cnt_q <= 4'h0;
		end
		else
		begin
			us_cnt_q <= us_cnt_d;
			ref_cnt_q <= ref_cnt_d;
			fast_cnt_q <= fast_cnt_d;
		end
	end

	// Software-written registers and APB slave
	logic [31:0] cfg_q [NC], cfg_d [NC];
	logic [31:0] fn_q [NC], fn_d [NC];
	logic [31:0] pre_q [NC], pre_d [NC];
	logic [31:0] sw_q [NC], sw_d [NC];
	logic [31:0] swprev_q [NC];
	logic [31:0] acc_w [NC], lat_w [NC];
	logic [31:0] prdata_d;
	logic pready_d, pslverr_d;
	logic [4:0] dec;
	logic access;

	// One wait state: pready rises in the second access cycle
	always_comb
	begin
		dec = decode(paddr);
		access = psel & penable & ~pready;
		pready_d = access;
		pslverr_d = access & ~dec[4];
		prdata_d = prdata;
		cfg_d = cfg_q;
		fn_d = fn_q;
		pre_d = pre_q;
		sw_d = sw_q;
		if (access)
		begin
			prdata_d = 32'h0000_0000;
			if (dec[4] && !pwrite)
			begin
				unique case (dec[2:0])
					3'h0: prdata_d = cfg_q[dec[3]];
					3'h1: prdata_d = fn_q[dec[3]];
					3'h2: prdata_d = pre_q[dec[3]];
					3'h3: prdata_d = sw_q[dec[3]];
					3'h4: prdata_d = acc_w[dec[3]];
					3'h5: prdata_d = lat_w[dec[3]];
					default: prdata_d = 32'h0000_0000;
				endcase
			end
		end
		// Writes land on the edge where the master sees pready
		if (psel && penable && pready && pwrite && dec[4])
		begin
			unique case (dec[2:0])
				3'h0: cfg_d[dec[3]] = pwdata;
				3'h1: fn_d[dec[3]] = pwdata;
				3'h2: pre_d[dec[3]] = pwdata;
				3'h3: sw_d[dec[3]] = pwdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			for (int c = 0; c < NC; c++)
			begin
				cfg_q[c] <= fast_pulse_counter_pkg::CFG_RST;
				fn_q[c] <= fast_pulse_counter_pkg::FN_RST;
				pre_q[c] <= fast_pulse_counter_pkg::PRE_RST;
				sw_q[c] <= fast_pulse_counter_pkg::SW_RST;
				swprev_q[c] <= fast_pulse_counter_pkg::SW_RST;
			end
		end
		else
		begin
			prdata <= prdata_d;
			pready <= pready_d;
			pslverr <= pslverr_d;
			cfg_q <= cfg_d;
			fn_q <= fn_d;
			pre_q <= pre_d;
			sw_q <= sw_d;
			swprev_q <= sw_q;
		end
	end

	// Two identical counters
	for (genvar c = 0; c < NC; c++)
	begin : g_cnt
		logic [31:0] acc_q, acc_d, lat_q, lat_d, meas_q, meas_d;
		logic [31:0] win_q, win_d, win_len, scale;
		logic [2:0] mode, sub;
		logic [1:0] inc_n, dec_n;
		logic [NF-1:0] trig;
		fast_pulse_counter_pkg::sig_t a, b;
		logic en2, ref_tick, q_up, q_dn, edge_end, in_span;

		assign acc_w[c] = acc_q;
		assign lat_w[c] = lat_q;

		// Special function triggers from pin or software source
		always_comb
		begin
			logic [2:0] src;
			logic [1:0] pol;
			logic lvl, prv;
			mode = cfg_q[c][fast_pulse_counter_pkg::CFG_MODE_LSB +: 3];
			src = 3'h0;
			pol = 2'h0;
			lvl = 1'b0;
			prv = 1'b0;
			for (int f = 0; f < NF; f++)
			begin
				src = fn_q[c][f * fast_pulse_counter_pkg::FN_STRIDE +: 3];
				pol = fn_q[c][f * fast_pulse_counter_pkg::FN_STRIDE
					+ fast_pulse_counter_pkg::FN_POL_LSB +: 2];
				lvl = 1'b0;
				prv = 1'b0;
				if (src < fast_pulse_counter_pkg::SRC_SW)
				begin
					lvl = flt_q[src[1:0]];
					prv = fprev_q[src[1:0]];
				end
				else if (src == fast_pulse_counter_pkg::SRC_SW)
				begin
					lvl = sw_q[c][f];
					prv = swprev_q[c][f];
				end
				trig[f] = fire(lvl, prv, pol) & allowed(mode, f);
			end
		end

		// Input mapping and per-mode count events
		always_comb
		begin
			sub = cfg_q[c][fast_pulse_counter_pkg::CFG_SUB_LSB +: 3];
			a = pin_ev[cfg_q[c][fast_pulse_counter_pkg::CFG_IN1_LSB +: 2]];
			b = pin_ev[cfg_q[c][fast_pulse_counter_pkg::CFG_IN2_LSB +: 2]];
			en2 = cfg_q[c][fast_pulse_counter_pkg::CFG_IN2_EN];
			ref_tick = cfg_q[c][fast_pulse_counter_pkg::CFG_REF_SEL]
				? slow_tick : fast_tick;
			// Phase one leading gives these four events
			q_up = (a.rise & ~b.lvl) | (b.rise & a.lvl)
				| (a.fall & b.lvl) | (b.fall & ~a.lvl);
			q_dn = (b.rise & ~a.lvl) | (a.rise & b.lvl)
				| (b.fall & a.lvl) | (a.fall & ~b.lvl);
			inc_n = 2'h0;
			dec_n = 2'h0;
			unique case (sub)
				fast_pulse_counter_pkg::TOT_INT: inc_n = {1'b0, ref_tick};
				fast_pulse_counter_pkg::TOT_UP:
					inc_n = {1'b0, a.rise} + {1'b0, en2 & b.rise};
				fast_pulse_counter_pkg::TOT_DOWN:
					dec_n = {1'b0, a.rise} + {1'b0, en2 & b.rise};
				fast_pulse_counter_pkg::TOT_UPDN:
				begin
					inc_n = {1'b0, a.rise};
					dec_n = {1'b0, b.rise};
				end
				fast_pulse_counter_pkg::TOT_CLKDIR:
				begin
					inc_n = {1'b0, a.rise & ~b.lvl};
					dec_n = {1'b0, a.rise & b.lvl};
				end
				default: ;
			endcase
			if (mode == fast_pulse_counter_pkg::MODE_QUAD)
			begin
				// Configuration selects the sense of rotation
				inc_n = {1'b0, sub[0] ? q_dn : q_up};
				dec_n = {1'b0, sub[0] ? q_up : q_dn};
			end
			// Width: end of the measured level; period: chosen edge
			edge_end = sub[0] ? a.rise : a.fall;
			in_span = sub[0] ? ~a.lvl : a.lvl;
			if (mode == fast_pulse_counter_pkg::MODE_PER)
			begin
				edge_end = sub[0] ? a.fall : a.rise;
				in_span = 1'b1;
			end
		end

		// Frequency window length in microseconds and hertz scale
		always_comb
		begin
			unique case (sub[1:0])
				2'h0: win_len = 32'(WIN0_US);
				2'h1: win_len = 32'(WIN1_US);
				2'h2: win_len = 32'(WIN2_US);
				2'h3: win_len = 32'(WIN3_US);
			endcase
			scale = 32'(fast_pulse_counter_pkg::US_PER_SEC) / win_len;
		end

		// Accumulator, measurement and latch next state
		always_comb
		begin
			acc_d = acc_q;
			lat_d = lat_q;
			meas_d = meas_q;
			win_d = win_q;
			unique case (mode)
				fast_pulse_counter_pkg::MODE_TOT,
				fast_pulse_counter_pkg::MODE_QUAD:
					acc_d = acc_q + 32'(inc_n) - 32'(dec_n);
				fast_pulse_counter_pkg::MODE_FREQ:
				begin
					meas_d = meas_q + 32'(a.rise);
					if (us_tick)
					begin
						win_d = win_q + 32'h0000_0001;
						if (win_q >= win_len - 32'h0000_0001)
						begin
							// Short windows answer fast, resolve coarsely
							acc_d = 32'(meas_d * scale);
							meas_d = 32'h0000_0000;
							win_d = 32'h0000_0000;
						end
					end
				end
				fast_pulse_counter_pkg::MODE_PW,
				fast_pulse_counter_pkg::MODE_PER:
				begin
					if (edge_end)
					begin
						acc_d = meas_q;
						meas_d = 32'h0000_0000;
					end
					else if (us_tick && in_span)
					begin
						meas_d = meas_q + 32'h0000_0001;
					end
				end
				default: ;
			endcase
			// Disable freezes the reported value only
			if (trig[fast_pulse_counter_pkg::FN_DIS])
			begin
				acc_d = acc_q;
			end
			// Clear or marker beats preload
			if (trig[fast_pulse_counter_pkg::FN_CLR]
				|| trig[fast_pulse_counter_pkg::FN_MRK])
			begin
				acc_d = 32'h0000_0000;
			end
			else if (trig[fast_pulse_counter_pkg::FN_PRE])
			begin
				acc_d = pre_q[c];
			end
			if (trig[fast_pulse_counter_pkg::FN_LAT])
			begin
				lat_d = acc_q;
			end
		end

		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				acc_q <= 32'h0000_0000;
				lat_q <= 32'h0000_0000;
				meas_q <= 32'h0000_0000;
				win_q <= 32'h0000_0000;
			end
			else
			begin
				acc_q <= acc_d;
				lat_q <= lat_d;
				meas_q <= meas_d;
				win_q <= win_d;
			end
		end
	end

endmodule

`default_nettype wire

// [fpc_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// Register port checks; the counting core is judged by the bench
module fpc_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Bus phases as the master presents them
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	// One wait state, so ready never comes at the first access edge
	AST_ONE_WAIT: assert property (
		s_setup ##1 s_access |-> !pready ##1 pready)
		else $error("ready not on second access edge");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	AST_READY_CAUSE: assert property (
		pready |-> $past(psel && penable) ##0 s_access)
		else $error("ready without a pending access");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("error flag without ready");
	AST_OUT_RANGE: assert property (
		pready && paddr >= 8'h40 |-> pslverr)
		else $error("address above both counters accepted");
	AST_HOLE: assert property (
		pready && paddr < 8'h40 && paddr[4:0] >= 5'h18 |-> pslverr)
		else $error("unmapped offset accepted");
	AST_MAPPED_OK: assert property (
		pready && paddr[4:0] < 5'h18 && paddr[1:0] == 2'h0
		&& paddr < 8'h40 |-> !pslverr)
		else $error("mapped offset refused");
	AST_ERR_READ_ZERO: assert property (
		pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned data");
	// Read data only moves with an answer, so no torn value is seen
	AST_RDATA_HOLD: assert property (!$stable(prdata) |-> pready)
		else $error("read data changed outside an answer");
endmodule
bind fast_pulse_counter fpc_sva chk_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// [pulse_source.sv]
`timescale 1ns/1ps
`default_nettype none
// Encoder or pulse source; pins driven from ph_q hold still between bursts, pins taken from aux follow aux
module pulse_source (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic quad,
	input wire logic rev,
	input wire logic [15:0] steps,
	input wire logic [15:0] half,
	input wire logic [2:0] aux,
	output logic busy,
	output logic [3:0] pins
);
	logic [15:0] left_q;
	logic [15:0] tick_q;
	logic [1:0] ph_q;
	// Phases walk 00,10,11,01; pulse mode steps by two so ph_q[0] stays 0
	assign pins[0] = quad ? ph_q[1] ^ ph_q[0] : ph_q[1];
	assign pins[1] = quad ? ph_q[1] : aux[0];
	assign pins[3:2] = aux[2:1];
	assign busy = left_q != 16'h0;
	// Each step lasts half cycles, well above the input filter minimum
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			left_q <= 16'h0;
			tick_q <= 16'h0;
			ph_q <= 2'h0;
		end
		else if (start)
		begin
			left_q <= steps;
			tick_q <= half;
		end
		else if (busy && tick_q <= 16'h1)
		begin
			ph_q <= ph_q + (quad ? (rev ? 2'h3 : 2'h1) : 2'h2);
			left_q <= left_q - 16'h1;
			tick_q <= half;
		end
		else if (busy)
			tick_q <= tick_q - 16'h1;
	end
endmodule
`default_nettype wire

// [fast_pulse_counter_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module fast_pulse_counter_bench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic start, quad, rev, busy;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r, p, v;
	logic [3:0] pin_in;
	logic [15:0] steps, half;
	logic [2:0] aux;
	int failures, checked, seed, n, c;
	time t0;
	int win[4] = '{10, 20, 25, 50};
	// sub, input one, input two, enable two, direction, count per rise
	int tc[8][6] = '{'{1,0,0,0,0,1}, '{1,0,0,1,0,2}, '{2,0,0,0,0,-1},
		'{2,0,0,1,0,-2}, '{3,0,2,1,0,1}, '{3,2,0,1,0,-1},
		'{4,0,1,1,0,1}, '{4,0,1,1,1,-1}};
	fast_pulse_counter #(.WIN0_US(10), .WIN1_US(20), .WIN2_US(25),
		.WIN3_US(50)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in));
	pulse_source src_u (.pclk(pclk), .presetn(presetn), .start(start),
		.quad(quad), .rev(rev), .steps(steps), .half(half), .aux(aux),
		.busy(busy), .pins(pin_in));
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// One transfer; only the watchdog bounds the wait for ready
	task automatic apb(input logic w, input int ch, input logic [7:0] o,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= o + (ch != 0 ? fast_pulse_counter_pkg::CNT_STRIDE : 8'h00);
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		while (pready !== 1'b1)
			@(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge, so a following call never drives psel twice at once
		@(posedge pclk);
	endtask
	task automatic sw(input logic [31:0] d);
		apb(1, 0, fast_pulse_counter_pkg::OFF_SW, d);
	endtask
	task automatic chk(input logic [31:0] x, input logic [31:0] g);
		checked++;
		if (g !== x)
		begin
			failures++;
			$display("Error at %0t: expected %h got %h", $time, x, g);
		end
	endtask
	// Timed results are off by one tick depending on phase
	task automatic near(input logic [31:0] x, input logic [31:0] g, input int t);
		checked++;
		if (^g === 1'bx || g - x + t > 2 * t)
		begin
			failures++;
			$display("Error at %0t: expected %h got %h", $time, x, g);
		end
	endtask
	task automatic acc(input int ch, input logic [31:0] x);
		apb(0, ch, fast_pulse_counter_pkg::OFF_ACC, 32'h0);
		chk(x, r);
	endtask
	task automatic cfgw(input int ch, input int m, input int s, input int a,
		input int b, input int en);
		apb(1, ch, fast_pulse_counter_pkg::OFF_CFG, {18'h0, 1'b0, en[0], b[1:0],
			a[1:0], 1'b0, s[2:0], 1'b0, m[2:0]});
	endtask
	function automatic logic [31:0] fld(input logic [31:0] w, input int f,
		input logic [2:0] s, input logic [1:0] pl);
		return (w & ~(32'h1F << (f * 6))) | ({27'h0, pl, s} << (f * 6));
	endfunction
	task automatic clr(input int ch);
		apb(1, ch, fast_pulse_counter_pkg::OFF_FN,
			fld(fast_pulse_counter_pkg::FN_RST, 3, 3'h4, 2'h0));
		apb(1, ch, fast_pulse_counter_pkg::OFF_SW, 32'h8);
		apb(1, ch, fast_pulse_counter_pkg::OFF_SW, 32'h0);
	endtask
	task automatic go(input int s, input logic q, input logic rv);
		steps <= 16'(s);
		quad <= q;
		rev <= rv;
		start <= 1'b1;
		@(posedge pclk);
		start <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic run(input int s, input logic q, input logic rv);
		go(s, q, rv);
		while (busy === 1'b1)
			@(posedge pclk);
		repeat (12) @(posedge pclk);
	endtask
	task automatic tally_and_finish;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		repeat (90000) @(posedge pclk);
		failures++;
		tally_and_finish;
	end
	initial
	begin
		seed = 63463;
		{presetn, psel, penable, pwrite, start, quad, rev} = 7'h00;
		{paddr, pwdata, steps, half, aux} = 75'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t0 = $time;
		@(posedge pclk);
		// Reset values, read-only accumulator, refused addresses
		for (c = 0; c < 2; c++)
		begin
			apb(1, c, fast_pulse_counter_pkg::OFF_ACC, $random(seed));
			for (n = 0; n < 6; n++)
			begin
				apb(0, c, 8'(4 * n), 32'h0);
				// Reset mode counts the fast reference, so ACC moves
				v = 32'(($time - t0)
					/ (10 * fast_pulse_counter_pkg::REF_FAST_CYCLES));
				if (n == 4)
					near(v, r, 2);
				else
					chk(n == 1 ? fast_pulse_counter_pkg::FN_RST : 32'h0, r);
			end
			apb(0, c, 8'h18, 32'h0);
			chk({r[30:0], e}, 32'h1);
		end
		apb(0, 0, 8'h40, 32'h0);
		chk({r[30:0], e}, 32'h1);
		$display("register test done");
		// Totalizer sub-modes on random bursts from pin zero
		for (n = 0; n < 8; n++)
		begin
			c = 2 * (($random(seed) & 7) + 1);
			half <= 16'(6 + ($random(seed) & 7));
			aux <= {2'b00, tc[n][4][0]};
			cfgw(0, 0, tc[n][0], tc[n][1], tc[n][2], tc[n][3]);
			clr(0);
			run(c, 1'b0, 1'b0);
			acc(0, 32'(tc[n][5] * c / 2));
		end
		aux <= 3'h0;
		$display("totalizer test done");
		// Quadrature on both counters, both senses, both directions
		for (n = 0; n < 8; n++)
		begin
			c = n / 4;
			cfgw(c, 4, n % 2, c, 1 - c, 1);
			clr(c);
			run(8, 1'b1, n[1]);
			v = (n[0] ^ n[1] ^ n[2]) ? 32'hFFFF_FFF8 : 32'h8;
			acc(c, v);
		end
		$display("quadrature test done");
		// Internal reference: counts over 1000 cycles at each rate
		for (n = 0; n < 2; n++)
		begin
			apb(1, 0, fast_pulse_counter_pkg::OFF_CFG, 32'(n) << 13);
			apb(0, 0, fast_pulse_counter_pkg::OFF_ACC, 32'h0);
			v = r;
			repeat (998) @(posedge pclk);
			apb(0, 0, fast_pulse_counter_pkg::OFF_ACC, 32'h0);
			near(n ? 32'hA : 32'h64, r - v, 1);
		end
		$display("reference test done");
		// Special functions through the software trigger word
		v = fld(fld(fast_pulse_counter_pkg::FN_RST, 0, 3'h4, 2'h0),
			1, 3'h4, 2'h3);
		v = fld(fld(v, 2, 3'h4, 2'h0), 3, 3'h4, 2'h0);
		cfgw(0, 0, 1, 0, 0, 0);
		apb(1, 0, fast_pulse_counter_pkg::OFF_FN, v);
		p = $random(seed);
		apb(1, 0, fast_pulse_counter_pkg::OFF_PRE, p);
		apb(0, 0, fast_pulse_counter_pkg::OFF_PRE, 32'h0);
		chk(p, r);
		sw(32'h4);
		sw(32'h0);
		acc(0, p);
		run(8, 1'b0, 1'b0);
		acc(0, p + 32'h4);
		sw(32'h2);
		sw(32'h0);
		apb(0, 0, fast_pulse_counter_pkg::OFF_LAT, 32'h0);
		chk(p + 32'h4, r);
		run(8, 1'b0, 1'b0);
		acc(0, p + 32'h8);
		sw(32'h1);
		run(8, 1'b0, 1'b0);
		sw(32'h0);
		acc(0, p + 32'h8);
		apb(1, 0, fast_pulse_counter_pkg::OFF_FN,
			fld(fld(v, 1, 3'h4, 2'h2), 2, 3'h4, 2'h1));
		acc(0, p);
		sw(32'h4);
		run(8, 1'b0, 1'b0);
		acc(0, p + 32'h4);
		sw(32'h6);
		sw(32'h4);
		apb(0, 0, fast_pulse_counter_pkg::OFF_LAT, 32'h0);
		chk(p + 32'h4, r);
		sw(32'h8);
		acc(0, 32'h0);
		// Marker from pin two clears a running quadrature count
		cfgw(0, 4, 0, 0, 1, 1);
		clr(0);
		apb(1, 0, fast_pulse_counter_pkg::OFF_FN,
			fld(fast_pulse_counter_pkg::FN_RST, 4, 3'h2, 2'h3));
		run(8, 1'b1, 1'b0);
		acc(0, 32'h8);
		aux <= 3'h2;
		repeat (12) @(posedge pclk);
		acc(0, 32'h0);
		aux <= 3'h0;
		$display("special function test done");
		// Width then period, both sub-modes, 2 us high and low
		half <= 16'h00C8;
		for (n = 0; n < 4; n++)
		begin
			cfgw(0, 2 + n / 2, n % 2, 0, 0, 0);
			run(8, 1'b0, 1'b0);
			apb(0, 0, fast_pulse_counter_pkg::OFF_ACC, 32'h0);
			v = n / 2 ? 32'h4 : 32'h2;
			near(v, r, 1);
		end
		v = r;
		apb(1, 0, fast_pulse_counter_pkg::OFF_FN,
			fld(fast_pulse_counter_pkg::FN_RST, 2, 3'h4, 2'h0));
		sw(32'h4);
		acc(0, v);
		sw(32'h0);
		$display("timing test done");
		// Frequency of a 200 kHz stream in every window
		half <= 16'h00FA;
		for (n = 0; n < 4; n++)
		begin
			cfgw(0, 1, n, 0, 0, 0);
			go(60, 1'b0, 1'b0);
			repeat (11000) @(posedge pclk);
			apb(0, 0, fast_pulse_counter_pkg::OFF_ACC, 32'h0);
			near(32'h0003_0D40, r, 1000000 / win[n]);
			run(0, 1'b0, 1'b0);
		end
		$display("frequency test done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
